//--- hw/lpam_pkg.sv
// Package for the linefeed power alarm monitor: register map, reset values, timing
`default_nettype none
package lpam_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CALC_RATE_HZ = 800;
    localparam int unsigned CALC_DIV_CYCLES = CLK_HZ / CALC_RATE_HZ;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PENDING = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_TH_A = 8'h10;
    localparam logic [7:0] OFS_TH_B = 8'h14;
    localparam logic [7:0] OFS_TH_C = 8'h18;
    localparam logic [7:0] OFS_POLE_A = 8'h1C;
    localparam logic [7:0] OFS_POLE_B = 8'h20;
    localparam logic [7:0] OFS_POLE_C = 8'h24;
    localparam logic [7:0] OFS_TOTAL = 8'h28;
    localparam logic [7:0] OFS_FILT0 = 8'h2C;
    localparam logic [15:0] TH_RST = 16'hFFFF;
    localparam logic [15:0] POLE_RST = 16'h0000;
    localparam logic [2:0] LF_OPEN = 3'h0;
    localparam logic [2:0] LF_RST = 3'h0;
    localparam logic [15:0] OFS_075V = 16'h0099;
    localparam int unsigned POLE_FRAC = 12;
    typedef enum logic [2:0] {
        LPAM_IDLE = 3'b001,
        LPAM_CALC = 3'b010,
        LPAM_CMP = 3'b100
    } lpam_state_t;
endpackage : lpam_pkg
`default_nettype wire

//--- hw/lpam_top.sv
// Linefeed power alarm monitor: power estimate, thermal filter, alarms and forced OPEN
// What this block does
// - Each sample period a power estimate is formed for every external transistor.
// - Discrete mode uses (|V|+0.75V)*I for Q1/Q2, battery minus drops for Q3..Q6.
// - Driver mode sums six terms; first four add 0.75V, last two use battery minus line.
// - The thermal sense pin selects driver mode, which rescales total power by 15/32; threshold A is unchanged.
// - Only the low-pass filtered power is compared with thresholds.
// - Calculation and filter update run at 800 Hz.
// - Pole coefficients are 13 bits plus sign, magnitude up to 4096, one per pair.
// - A filtered power above its pair threshold raises that transistor's alarm.
// - A pending bit sets on a rising comparator edge and stays until cleared.
// - Each pending bit has an enable that masks its interrupt.
// - Driver mode compares only total power, filtered with pole A, against threshold A.
// - Driver mode reports through the first pending and enable bits only.
// - Any exceeded threshold forces the linefeed state to OPEN.
// - Forced OPEN ignores masking and lasts until software writes a new state.
//
// The APB register port and the address map were chosen for this implementation.
`default_nettype none
module lpam_top
    import lpam_pkg::*;
#(
    parameter int unsigned DIV_CYCLES = CALC_DIV_CYCLES,
    parameter int unsigned SENSE_R_SHIFT = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] v_tip,
    input wire logic [15:0] v_ring,
    input wire logic [15:0] v_bat,
    input wire logic [95:0] i_q,
    input wire logic thermal_sense_pin,
    output logic [2:0] linefeed_state,
    output logic forced_open,
    output logic irq
);
    // Unsigned saturating add/sub and 16x16 product scaled back to 16 bits
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[16] ? 16'hFFFF : s[15:0];
    endfunction : sat_add
    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        sat_sub = (a > b) ? a - b : 16'h0000;
    endfunction : sat_sub
    function automatic logic [15:0] pmul(input logic [15:0] v, input logic [15:0] i);
        logic [31:0] p;
        p = v * i;
        pmul = (p[31:28] != 4'h0) ? 16'hFFFF : p[27:12];
    endfunction : pmul
    function automatic logic [15:0] vabs(input logic [15:0] v);
        vabs = v[15] ? 16'(-v) : v;
    endfunction : vabs
    // Writes are clamped to +/-4096, so one step covers at most an eighth of the gap to the target
    // The sign bit is kept so a negative pole still has its magnitude limited
    function automatic logic [15:0] pole_lim(input logic [15:0] w);
        logic signed [15:0] s;
        s = $signed(w);
        if (s > 16'sh1000) begin
            pole_lim = 16'h1000;
        end else if (s < -16'sh1000) begin
            pole_lim = 16'hF000;
        end else begin
            pole_lim = w;
        end
    endfunction : pole_lim

    // Three-stage sync on the sense pin; only stages 2 and 3 are looked at
    // A slow pin, so mode changes lag by three or four cycles, well ahead of a tick
    logic [2:0] thermal_sense_pin_sync_q;
    logic drv_mode_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thermal_sense_pin_sync_q <= 3'b000;
            drv_mode_q <= 1'b0;
        end else begin
            thermal_sense_pin_sync_q <= {thermal_sense_pin_sync_q[1:0], thermal_sense_pin};
            if (thermal_sense_pin_sync_q[2] == thermal_sense_pin_sync_q[1]) begin
                drv_mode_q <= thermal_sense_pin_sync_q[2];
            end
        end
    end

    // 800 Hz calculation tick
    // Counter restarts at the tick, giving one pulse every DIV_CYCLES clocks
    logic [31:0] div_q;
    wire tick = (div_q == DIV_CYCLES - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 32'h0000_0000;
        end else begin
            div_q <= tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
        end
    end

    // Registers
    logic [15:0] th_q [3];
    logic [15:0] pole_q [3];
    logic [5:0] pend_q;
    logic [5:0] en_q;
    logic [2:0] lf_q;
    logic forced_q;
    logic [15:0] filt_q [6];
    logic [15:0] total_q;
    logic [5:0] cmp_q;

    wire [15:0] i1 = i_q[15:0];
    wire [15:0] i2 = i_q[31:16];
    wire [15:0] i3 = i_q[47:32];
    wire [15:0] i4 = i_q[63:48];
    wire [15:0] i5 = i_q[79:64];
    wire [15:0] i6 = i_q[95:80];
    wire [15:0] at = vabs(v_tip);
    wire [15:0] ar = vabs(v_ring);
    wire [15:0] ab = vabs(v_bat);
    // Sense resistor drop approximated as a current shift, keeping the multiplier count low
    wire [15:0] drop5 = i5 >> SENSE_R_SHIFT;
    wire [15:0] drop6 = i6 >> SENSE_R_SHIFT;
    // Power terms are (V*I)>>12 clipped to 16 bits; voltage drops never go below zero
    // Discrete-mode terms feed one filter each
    wire [15:0] p1 = pmul(sat_add(at, OFS_075V), i1);
    wire [15:0] p2 = pmul(sat_add(ar, OFS_075V), i2);
    wire [15:0] p3d = pmul(sat_sub(ab, drop5), i3);
    wire [15:0] p4d = pmul(sat_sub(ab, drop6), i4);
    wire [15:0] p5d = pmul(sat_sub(sat_sub(ab, ar), drop5), i5);
    wire [15:0] p6d = pmul(sat_sub(sat_sub(ab, at), drop6), i6);
    // Driver-mode terms; the Q1 and Q2 terms are shared with discrete mode
    wire [15:0] p3i = pmul(sat_add(ab, OFS_075V), i3);
    wire [15:0] p4i = pmul(sat_add(ab, OFS_075V), i4);
    wire [15:0] p5i = pmul(sat_sub(ab, ar), i5);
    wire [15:0] p6i = pmul(sat_sub(ab, at), i6);
    // Saturating sum: a wrapped total would hide an overload
    // Driver-mode scale 498/1059.6 ~ 15/32 applied to the sum
    wire [15:0] total_power_value_raw = sat_add(sat_add(sat_add(p1, p2), sat_add(p3i, p4i)), sat_add(p5i, p6i));
    wire [19:0] total_power_value_scl = {4'h0, total_power_value_raw} * 20'd15;
    wire [15:0] total_power_value = {1'b0, total_power_value_scl[19:5]};
    // Filter slots 1..5 keep running in driver mode but can no longer raise an alarm
    wire [15:0] pw [6];
    assign pw[0] = drv_mode_q ? total_power_value : p1;
    assign pw[1] = p2;
    assign pw[2] = p3d;
    assign pw[3] = p4d;
    assign pw[4] = p5d;
    assign pw[5] = p6d;

    // Filter update and comparison, once per tick
    // Pole sits in 1/8 units of 2^-12, hence the extra shift of three
    // Comparator is strictly greater, so a threshold of all ones can never trip
    logic [15:0] filt_d [6];
    logic [5:0] cmp_d;
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            logic signed [17:0] diff;
            logic signed [31:0] step;
            logic signed [17:0] nxt;
            diff = $signed({2'b00, pw[k]}) - $signed({2'b00, filt_q[k]});
            step = (diff * $signed({{2{pole_q[k/2][15]}}, pole_q[k/2]})) >>> (POLE_FRAC + 3);
            nxt = $signed({2'b00, filt_q[k]}) + step[17:0];
            filt_d[k] = nxt[17] ? 16'h0000 : (nxt[16] ? 16'hFFFF : nxt[15:0]);
            cmp_d[k] = filt_d[k] > th_q[k/2];
        end
        if (drv_mode_q) begin
            cmp_d[5:1] = 5'b00000;
        end
    end

    // APB decode
    // Zero wait states: pready is tied high and pslverr flags holes in the map
    wire wr = psel && penable && pwrite;
    wire rd_ok;
    logic [31:0] rdata_c;
    always_comb begin
        rdata_c = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: rdata_c = {29'h0, lf_q};
            OFS_STATUS: rdata_c = {30'h0, forced_q, drv_mode_q};
            OFS_PENDING: rdata_c = {26'h0, pend_q};
            OFS_ENABLE: rdata_c = {26'h0, en_q};
            OFS_TH_A: rdata_c = {16'h0, th_q[0]};
            OFS_TH_B: rdata_c = {16'h0, th_q[1]};
            OFS_TH_C: rdata_c = {16'h0, th_q[2]};
            OFS_POLE_A: rdata_c = {16'h0, pole_q[0]};
            OFS_POLE_B: rdata_c = {16'h0, pole_q[1]};
            OFS_POLE_C: rdata_c = {16'h0, pole_q[2]};
            OFS_TOTAL: rdata_c = {16'h0, total_q};
            OFS_FILT0: rdata_c = {16'h0, filt_q[0]};
            default: rdata_c = 32'h0000_0000;
        endcase
    end
    assign rd_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_FILT0);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !rd_ok;

    wire [5:0] rise = cmp_d & ~cmp_q;
    wire alarm_ev = tick && (|cmp_d);

    // One write strobe per register keeps the clocked blocks free of address compares
    wire wr_ctrl = wr && (paddr == OFS_CTRL);
    wire wr_pending = wr && (paddr == OFS_PENDING);
    wire wr_enable = wr && (paddr == OFS_ENABLE);
    wire [2:0] wr_th;
    wire [2:0] wr_pole;
    assign wr_th[0] = wr && (paddr == OFS_TH_A);
    assign wr_th[1] = wr && (paddr == OFS_TH_B);
    assign wr_th[2] = wr && (paddr == OFS_TH_C);
    assign wr_pole[0] = wr && (paddr == OFS_POLE_A);
    assign wr_pole[1] = wr && (paddr == OFS_POLE_B);
    assign wr_pole[2] = wr && (paddr == OFS_POLE_C);
    wire [5:0] clr = wr_pending ? pwdata[5:0] : 6'h00;

    // Read data is captured in the setup cycle, so the access phase needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rdata_c;
        end
    end

    // Filter state, last comparator levels and the total power snapshot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < 6; k++) begin
                filt_q[k] <= 16'h0000;
            end
            total_q <= 16'h0000;
            cmp_q <= 6'h00;
        end else if (tick) begin
            for (int k = 0; k < 6; k++) begin
                filt_q[k] <= filt_d[k];
            end
            cmp_q <= cmp_d;
            total_q <= total_power_value;
        end
    end

    // Pending bits: a rising comparator at a tick beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 6'h00;
        end else begin
            pend_q <= (pend_q & ~clr) | (tick ? rise : 6'h00);
        end
    end

    // Software-owned settings: enables, thresholds and clamped poles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 6'h00;
            for (int k = 0; k < 3; k++) begin
                th_q[k] <= TH_RST;
                pole_q[k] <= POLE_RST;
            end
        end else begin
            if (wr_enable) begin
                en_q <= pwdata[5:0];
            end
            for (int k = 0; k < 3; k++) begin
                if (wr_th[k]) begin
                    th_q[k] <= pwdata[15:0];
                end
                if (wr_pole[k]) begin
                    pole_q[k] <= pole_lim(pwdata[15:0]);
                end
            end
        end
    end

    // Alarm beats a same-cycle state write so a hot line never stays powered;
    // the mask is not consulted here, only for the interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_q <= LF_RST;
            forced_q <= 1'b0;
        end else if (alarm_ev) begin
            lf_q <= LF_OPEN;
            forced_q <= 1'b1;
        end else if (wr_ctrl) begin
            lf_q <= pwdata[2:0];
            forced_q <= 1'b0;
        end
    end

    // State and forced flag leave straight from their flip-flops
    assign linefeed_state = lf_q;
    assign forced_open = forced_q;
    // Interrupt is a level; it drops as soon as software clears or masks the bit
    assign irq = |(pend_q & en_q);
endmodule : lpam_top
`default_nettype wire

//--- verif/lpam_line_model.sv
// Far-side model: line voltages and per-transistor currents
`default_nettype none
module lpam_line_model (
    input wire logic pclk,
    input wire logic [5:0] on_mask,
    input wire logic [11:0] level,
    output logic [15:0] v_tip,
    output logic [15:0] v_ring,
    output logic [15:0] v_bat,
    output logic [95:0] i_q
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge pclk) begin
        v_tip <= 16'h0100;
        v_ring <= 16'h0100;
        v_bat <= 16'h4000;
        for (int k = 0; k < 6; k++) begin
            i_q[k*16 +: 16] <= on_mask[k] ? {4'h0, level} : 16'h0000;
        end
    end
endmodule : lpam_line_model
`default_nettype wire

//--- verif/lpam_top_assertions.sv
// Port checker for the linefeed power alarm monitor
`default_nettype none
module lpam_top_chk
    import lpam_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] linefeed_state,
    input wire logic forced_open,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic acc = psel && penable;
    wire logic ctrl_wr = acc && pwrite && paddr == OFS_CTRL;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_unmapped: assert property (acc && (paddr > OFS_FILT0 || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("bad address accepted");
    chk_ok_mapped: assert property (acc && paddr <= OFS_FILT0 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("good address refused");
    chk_err_data: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    chk_open_forced: assert property ($rose(forced_open) |-> linefeed_state == LF_OPEN)
        else $error("forced without OPEN");
    chk_open_holds: assert property (forced_open && !ctrl_wr |=> forced_open)
        else $error("forced OPEN dropped");
    chk_state_cause: assert property ($changed(linefeed_state) |-> $past(ctrl_wr) || linefeed_state == LF_OPEN)
        else $error("state changed alone");
    chk_irq_cause: assert property ($rose(irq) |-> $past(acc && pwrite) || forced_open)
        else $error("irq without cause");
    chk_status_open: assert property (acc && !pwrite && paddr == OFS_STATUS |-> prdata[1] == $past(forced_open))
        else $error("status open bit wrong");
    chk_forced_state: assert property (forced_open |-> linefeed_state == LF_OPEN)
        else $error("forced flag without OPEN state");
    cover property ($rose(forced_open));
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule : lpam_top_chk
bind lpam_top lpam_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .linefeed_state(linefeed_state),
    .forced_open(forced_open), .irq(irq));
`default_nettype wire

//--- verif/linefeed_power_alarm_monitor_tb.sv
// Self-checking bench for the linefeed power alarm monitor
`default_nettype none
module linefeed_power_alarm_monitor_tb;
    import lpam_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 20;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, thermal_sense_pin, forced_open, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] v_tip, v_ring, v_bat;
    logic [95:0] i_q;
    logic [2:0] linefeed_state;
    logic [5:0] on_mask, en, xp;
    logic [11:0] level;
    int failures, checks_done, seed;
    lpam_top #(.DIV_CYCLES(DIV)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .v_tip(v_tip), .v_ring(v_ring), .v_bat(v_bat), .i_q(i_q), .thermal_sense_pin(thermal_sense_pin),
        .linefeed_state(linefeed_state), .forced_open(forced_open), .irq(irq));
    lpam_line_model u_line (.pclk(pclk), .on_mask(on_mask), .level(level), .v_tip(v_tip), .v_ring(v_ring),
        .v_bat(v_bat), .i_q(i_q));
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Holds the whole request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] pole_for(input longint tau_us);
        return 32'((64'd32768 * 1000000 + 800 * tau_us - 1) / (800 * tau_us));
    endfunction : pole_for
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        conclude();
    end
    initial begin
        seed = 37399;
        {psel, penable, pwrite, paddr, pwdata, on_mask, level, thermal_sense_pin, presetn} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFS_TH_A, 0);
        check(r, 32'h0000_FFFF);
        apb(0, 8'h40, 0);
        check(32'(e), 1);
        check(r, 0);
        for (int t = 0; t < 8; t++) begin
            presetn <= 1'b0;
            on_mask <= '0;
            thermal_sense_pin <= (t % 3 == 2);
            level <= 12'h100 | 12'($random(seed));
            en = 6'($random(seed));
            xp = (t == 1) ? 6'h00 : (t == 0 || t == 4) ? 6'h3F : 6'($random(seed));
            repeat (6) @(posedge pclk);
            presetn <= 1'b1;
            apb(1, OFS_CTRL, 3);
            for (int k = 0; k < 3; k++) begin
                apb(1, 8'(OFS_TH_A + 4 * k), 0);
                apb(1, 8'(OFS_POLE_A + 4 * k), t == 4 ? 0 : pole_for(10000));
            end
            apb(1, OFS_ENABLE, 32'(en));
            on_mask <= xp;
            repeat (12 * DIV) @(posedge pclk);
            // A still pole keeps the filter at zero whatever the raw power
            xp = (t == 4) ? 6'h00 : thermal_sense_pin ? {5'h00, |xp} : xp;
            apb(0, OFS_PENDING, 0);
            check(r, 32'(xp));
            check(32'(irq), 32'(|(xp & en)));
            check(32'(linefeed_state), xp != 0 ? 32'(LF_OPEN) : 3);
            apb(0, OFS_STATUS, 0);
            check(32'(r[1:0]), {30'h0, xp != 0, thermal_sense_pin});
            if (xp != 0) begin
                for (int k = 0; k < 3; k++) begin
                    apb(1, 8'(OFS_TH_A + 4 * k), 32'h0000_FFFF);
                end
                apb(1, OFS_CTRL, 5);
                apb(0, OFS_CTRL, 0);
                check(32'(linefeed_state), 5);
                check(32'(forced_open), 0);
                apb(0, OFS_PENDING, 0);
                check(r, 32'(xp));
                apb(1, OFS_PENDING, 32'(xp));
                apb(0, OFS_PENDING, 0);
                check(r, 0);
                check(32'(irq), 0);
            end
        end
        conclude();
    end
endmodule : linefeed_power_alarm_monitor_tb
`default_nettype wire
